// *** bench/sslc_assertions.sv ***
// port checker for the strap and load controller
// assumes binding onto sslc_strap_load_ctrl
`timescale 1ns/1ns
`default_nettype none
module sslc_chk (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic i_eeprom_ok,
	input wire logic i_eeprom_fail,
	input wire logic o_eeprom_start,
	input wire logic o_done_n,
	input wire logic o_done_oe_n,
	input wire logic [6:0] o_target_addr,
	input wire logic o_master_mode
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_rel_idle: assert property ($rose(i_rst_n) |-> o_done_n && o_done_oe_n)
		else $error("done pin not idle after reset");
	a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("apb ready too long");
	a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside access");
	a_start_master: assert property (o_eeprom_start |-> o_master_mode)
		else $error("load start outside master mode");
	a_done_ok: assert property (o_master_mode && i_eeprom_ok |-> ##[1:3] !o_done_n)
		else $error("done not low after good load");
	a_done_hold: assert property (o_master_mode && !o_done_n |=> !o_done_n)
		else $error("done released");
	a_fail_high: assert property (o_master_mode && i_eeprom_fail |-> ##1 o_done_n [*3])
		else $error("done low after failed load");
	a_slave_low: assert property (!o_master_mode && !o_done_oe_n |-> !o_done_n)
		else $error("slave done pin driven high");
	a_addr_hold: assert property (o_target_addr != 0 |=> $stable(o_target_addr))
		else $error("target address moved");
	c_load: cover property (i_eeprom_ok ##[1:3] !o_done_n);
	c_hold: cover property (!o_master_mode && !o_done_oe_n);
	c_err: cover property (o_pready && o_pslverr);
endmodule
bind sslc_strap_load_ctrl sslc_chk chk_u (.i_sys_clk, .i_rst_n, .i_psel, .i_penable,
	.o_pready, .o_prdata, .o_pslverr, .i_eeprom_ok, .i_eeprom_fail, .o_eeprom_start,
	.o_done_n, .o_done_oe_n, .o_target_addr, .o_master_mode);
`default_nettype wire

// *** bench/sslc_eeprom_model.sv ***
// eeprom side stand-in: answers each start pulse with a load result
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ns
`default_nettype none
module sslc_eeprom_model (
	input wire logic i_clk,
	input wire logic i_start,
	input wire logic i_bad,
	output logic o_ok,
	output logic o_fail,
	output logic o_scl
);
	// bus clock idles high through its pull-up, runs only while loading
	// slave-mode host traffic is never clocked here, so no 400 kHz bound arises
	initial begin
		o_ok = 0;
		o_fail = 0;
		o_scl = 1;
	end
	always @(posedge i_clk) begin
		if (i_start === 1'b1) begin
			#7;
			repeat (8) #160 o_scl = ~o_scl;
			@(posedge i_clk);
			o_ok <= !i_bad;
			o_fail <= i_bad;
			@(posedge i_clk);
			o_ok <= 0;
			o_fail <= 0;
		end
	end
endmodule
`default_nettype wire

// *** bench/sslc_strap_load_ctrl_test.sv ***
// testbench: straps, eeprom load, slave hold and cross-point over apb
// assumes the eeprom model answers every start pulse
`timescale 1ns/1ns
`default_nettype none
module sslc_strap_load_ctrl_test;
	logic clk, rst_n, psel, pen, pwr, req_n, sa, sb, bad, pready, slverr, ok, fl, scl;
	logic start, smr, done_n, doe_n, mm, tm, irq;
	logic [31:0] paddr, pwdata, prdata;
	logic [1:0] alo, ahi, md;
	logic [6:0] tgt, ea;
	logic [3:0] cr;
	logic [32:0] q[$];
	int failures, checked, n, k;
	sslc_strap_load_ctrl dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr), .i_addr_strap_lo(alo),
		.i_addr_strap_hi(ahi), .i_mgmt_mode_strap(md), .i_xpoint_sel_a(sa),
		.i_xpoint_sel_b(sb), .i_load_req_n(req_n), .i_mgmt_bus_clock_pin(scl),
		.i_eeprom_ok(ok), .i_eeprom_fail(fl), .o_eeprom_start(start), .o_mgmt_sm_rst(smr),
		.o_done_n(done_n), .o_done_oe_n(doe_n), .o_target_addr(tgt), .o_master_mode(mm),
		.o_test_mode(tm), .o_xpoint_cross(cr), .o_irq(irq));
	sslc_eeprom_model pm_u (.i_clk(clk), .i_start(start), .i_bad(bad), .o_ok(ok),
		.o_fail(fl), .o_scl(scl));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task chk(input string nm, input logic [32:0] g, input logic [32:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// reads queue their expectation; the monitor pops it when the answer stands
	task apb(input logic w, input logic [5:0] i, input logic [31:0] d, input logic [32:0] e);
		psel <= 1;
		pwr <= w;
		paddr <= {24'h0, i, 2'b00};
		pwdata <= d;
		if (!w) q.push_back(e);
		@(posedge clk) pen <= 1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	always @(posedge clk) if (pready === 1'b1 && pwr === 1'b0)
		chk("read", {slverr, prdata}, q.pop_front());
	// straps stay put well past capture, which lands some five edges after release
	task rs(input logic [1:0] m, input logic [1:0] l, input logic [1:0] h);
		rst_n <= 0;
		md <= m;
		alo <= l;
		ahi <= h;
		req_n <= 1;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (14) @(posedge clk);
	endtask
	initial begin
		#400000;
		failures++;
		wrap_up;
	end
	initial begin
		{psel, pen, pwr, sa, sb, bad, rst_n, alo, ahi} = 0;
		{paddr, pwdata} = 0;
		req_n = 1;
		md = 2;
		failures = 0;
		checked = 0;
		n = $urandom(2400);
		k = $urandom % 16;
		ea = 7'h20 + k[6:0];
		rs(2, k[1:0], k[3:2]);
		chk("addr", tgt, ea);
		chk("mode", {tm, mm}, 2'b01);
		apb(0, 2, 0, {17'h0, 1'b0, ea, 8'h0b});
		apb(0, 4, 0, {1'b1, 32'h0});
		apb(1, 1, 1, 0);
		req_n <= 0;
		n = 0;
		while (done_n !== 1'b0 && n < 300) begin @(posedge clk); n++; end
		repeat (3) @(posedge clk);
		chk("irq", irq, 1);
		repeat (20) @(posedge clk);
		chk("done", done_n, 0);
		apb(0, 0, 0, 33'h1);
		repeat (2) @(posedge clk);
		chk("irq clr", irq, 0);
		apb(1, 5, 2, 0);
		for (k = 0; k < 4; k++) begin
			{sb, sa} <= k[1:0];
			repeat (8) @(posedge clk);
			chk("cross", cr, {k[1:0], k[1:0]});
		end
		apb(1, 5, 0, 0);
		apb(1, 3, 9, 0);
		{sb, sa} <= 2'b00;
		repeat (8) @(posedge clk);
		chk("cross reg", cr, 4'h9);
		bad <= 1;
		rs(2, 0, 0);
		req_n <= 0;
		repeat (80) @(posedge clk);
		chk("fail", done_n, 1);
		apb(0, 0, 0, 33'h2);
		bad <= 0;
		rs(1, 0, 0);
		req_n <= 0;
		repeat (20) @(posedge clk);
		chk("test", {tm, doe_n}, 2'b11);
		rs(3, 0, 0);
		chk("slave idle", doe_n, 1);
		apb(1, 1, 7, 0);
		req_n <= 0;
		n = 0;
		while (doe_n !== 1'b0 && n < 50) begin @(posedge clk); n++; end
		chk("slave", {done_n, smr}, 2'b01);
		req_n <= 1;
		repeat (10) @(posedge clk);
		chk("chain", doe_n, 0);
		apb(0, 1, 0, 0);
		wrap_up;
	end
endmodule
`default_nettype wire

// *** verilog/sslc_defs.vh ***
// constants for the strap and eeprom load controller
// assumes a 25 MHz system clock and a 32-bit apb register bus
`ifndef SSLC_DEFS_VH
`define SSLC_DEFS_VH

// register indices, byte address is four times the index
`define SSLC_IDX_STATUS 6'h00
`define SSLC_IDX_MASK 6'h01
`define SSLC_IDX_INFO 6'h02
`define SSLC_IDX_XPT 6'h03
`define SSLC_IDX_SHARED 6'h05
`define SSLC_IDX_W 6

// shared register pin-control bit
`define SSLC_SH_PINCTL 1
`define SSLC_SH_W 8
`define SSLC_SH_RST 8'h00

// status and mask bits
`define SSLC_EV_W 3
`define SSLC_EV_LOAD_OK 0
`define SSLC_EV_LOAD_FAIL 1
`define SSLC_EV_HOLD 2
`define SSLC_EV_RST 3'h0

// strap level codes
`define SSLC_LVL_0 2'h0
`define SSLC_LVL_R 2'h1
`define SSLC_LVL_F 2'h2
`define SSLC_LVL_1 2'h3

// load state machine
`define SSLC_LD_IDLE 2'h0
`define SSLC_LD_RUN 2'h1
`define SSLC_LD_OK 2'h2
`define SSLC_LD_FAIL 2'h3

// input synchroniser layout
`define SSLC_NSYNC 10
`define SSLC_SY_ALO 0
`define SSLC_SY_AHI 2
`define SSLC_SY_MODE 4
`define SSLC_SY_SELA 6
`define SSLC_SY_SELB 7
`define SSLC_SY_REQ 8
`define SSLC_SY_SDC 9
`define SSLC_SYNC_RST 10'h3ff

// cycles for the filtered straps to settle before capture
`define SSLC_SETTLE 3'h4
`define SSLC_NPAIR 4
`define SSLC_ADDR_W 7
`define SSLC_EDGE_W 16

`endif

// *** verilog/sslc_strap_load_ctrl.v ***
// strap decode, eeprom auto-load control, slave reset chain and cross-point select
// assumes an apb master on i_sys_clk and an smbus engine that reports load result
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sslc_defs.vh"

module sslc_strap_load_ctrl #(
	parameter [16*`SSLC_ADDR_W-1:0] ADDR_TABLE = {7'h2f, 7'h2e, 7'h2d, 7'h2c,
		7'h2b, 7'h2a, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25, 7'h24,
		7'h23, 7'h22, 7'h21, 7'h20}
) (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [31:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	input wire [1:0] i_addr_strap_lo,
	input wire [1:0] i_addr_strap_hi,
	input wire [1:0] i_mgmt_mode_strap,
	input wire i_xpoint_sel_a,
	input wire i_xpoint_sel_b,
	input wire i_load_req_n,
	input wire i_mgmt_bus_clock_pin,
	input wire i_eeprom_ok,
	input wire i_eeprom_fail,
	output reg o_eeprom_start,
	output reg o_mgmt_sm_rst,
	output reg o_done_n,
	output reg o_done_oe_n,
	output reg [`SSLC_ADDR_W-1:0] o_target_addr,
	output reg o_master_mode,
	output reg o_test_mode,
	output reg [`SSLC_NPAIR-1:0] o_xpoint_cross,
	output reg o_irq
);

	wire [`SSLC_NSYNC-1:0] pins;
	wire [`SSLC_NSYNC-1:0] sync_rst;
	reg [`SSLC_NSYNC-1:0] sy1;
	reg [`SSLC_NSYNC-1:0] sy2;
	reg [`SSLC_NSYNC-1:0] sy3;
	reg [`SSLC_NSYNC-1:0] filt;
	reg [2:0] settle;
	reg captured;
	reg [3:0] strap_idx;
	reg [1:0] mode_lvl;
	reg [1:0] ld_state;
	reg [1:0] next_ld_state;
	reg [`SSLC_EV_W-1:0] status;
	reg [`SSLC_EV_W-1:0] mask;
	reg [`SSLC_SH_W-1:0] shared;
	reg [`SSLC_NPAIR-1:0] xpt_reg;
	reg [`SSLC_EDGE_W-1:0] edge_cnt;
	reg sdc_prev;
	reg hold_seen;
	wire master_mode;
	wire slave_mode;
	wire slave_hold;
	wire reg_rst;
	wire req_low;
	wire sdc_rise;
	wire apb_req;
	wire [`SSLC_IDX_W-1:0] idx;
	wire addr_ok;
	wire rd_status;
	wire [`SSLC_EV_W-1:0] ev_set;
	wire ev_ok;
	wire ev_fail;
	wire ev_hold;
	wire [`SSLC_NPAIR-1:0] pin_cross;
	reg [31:0] rd_mux;

	// load request and select pins are pulled up on the pad; request is active low, select pins are active high
	assign pins = {i_mgmt_bus_clock_pin, i_load_req_n, i_xpoint_sel_b, i_xpoint_sel_a,
		i_mgmt_mode_strap, i_addr_strap_hi, i_addr_strap_lo};

	// all stages reset to the pulled-up idle level so release gives no false edge
	assign sync_rst = `SSLC_SYNC_RST;

	// three stages per pin; the filtered value moves only when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < `SSLC_NSYNC; g = g + 1) begin : g_sync
			always @(posedge i_sys_clk) begin
				if (!i_rst_n) begin
					sy1[g] <= sync_rst[g];
					sy2[g] <= sync_rst[g];
					sy3[g] <= sync_rst[g];
					filt[g] <= sync_rst[g];
				end else begin
					sy1[g] <= pins[g];
					sy2[g] <= sy1[g];
					sy3[g] <= sy2[g];
					if (sy2[g] == sy3[g]) begin
						filt[g] <= sy3[g];
					end
				end
			end
		end
	endgenerate

	assign req_low = ~filt[`SSLC_SY_REQ];
	assign master_mode = captured && (mode_lvl == `SSLC_LVL_F);
	assign slave_mode = captured && (mode_lvl == `SSLC_LVL_1);
	assign slave_hold = slave_mode && req_low;
	assign reg_rst = !i_rst_n || slave_hold;
	assign sdc_rise = filt[`SSLC_SY_SDC] && !sdc_prev;

	// straps are caught once after the filters settle and never again;
	// a slave-mode hold does not recapture since the address must persist
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			settle <= 3'h0;
			captured <= 1'b0;
			strap_idx <= 4'h0;
			mode_lvl <= `SSLC_LVL_F;
		end else if (!captured) begin
			if (settle == `SSLC_SETTLE) begin
				captured <= 1'b1;
				strap_idx <= {filt[`SSLC_SY_AHI+1:`SSLC_SY_AHI],
					filt[`SSLC_SY_ALO+1:`SSLC_SY_ALO]};
				mode_lvl <= filt[`SSLC_SY_MODE+1:`SSLC_SY_MODE];
			end else begin
				settle <= settle + 3'h1;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_target_addr <= {`SSLC_ADDR_W{1'b0}};
			o_master_mode <= 1'b0;
			o_test_mode <= 1'b0;
		end else begin
			// held at zero until capture so the address moves exactly once
			if (captured) begin
				o_target_addr <= ADDR_TABLE[strap_idx*`SSLC_ADDR_W +: `SSLC_ADDR_W];
			end
			o_master_mode <= master_mode;
			// reserved and test levels disable both master load and slave hold
			o_test_mode <= captured && (mode_lvl == `SSLC_LVL_R);
		end
	end

	// load sequencer: a failed load retries only after the request is released
	always @* begin
		next_ld_state = ld_state;
		case (ld_state)
			`SSLC_LD_IDLE: begin
				if (master_mode && req_low) begin
					next_ld_state = `SSLC_LD_RUN;
				end
			end
			`SSLC_LD_RUN: begin
				if (i_eeprom_ok) begin
					next_ld_state = `SSLC_LD_OK;
				end else if (i_eeprom_fail) begin
					next_ld_state = `SSLC_LD_FAIL;
				end
			end
			`SSLC_LD_OK: begin
				next_ld_state = `SSLC_LD_OK;
			end
			`SSLC_LD_FAIL: begin
				if (!req_low) begin
					next_ld_state = `SSLC_LD_IDLE;
				end
			end
			default: begin
				next_ld_state = `SSLC_LD_IDLE;
			end
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ld_state <= `SSLC_LD_IDLE;
			o_eeprom_start <= 1'b0;
		end else begin
			ld_state <= next_ld_state;
			o_eeprom_start <= (ld_state == `SSLC_LD_IDLE) &&
				(next_ld_state == `SSLC_LD_RUN);
		end
	end

	// done pin: push-pull in master mode, floats in slave mode until the first hold
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			hold_seen <= 1'b0;
			o_done_n <= 1'b1;
			o_done_oe_n <= 1'b1;
			o_mgmt_sm_rst <= 1'b1;
		end else begin
			o_mgmt_sm_rst <= slave_hold;
			if (slave_hold) begin
				hold_seen <= 1'b1;
			end
			if (slave_mode) begin
				o_done_n <= 1'b0;
				o_done_oe_n <= !(hold_seen || slave_hold);
			end else if (master_mode) begin
				o_done_n <= (ld_state != `SSLC_LD_OK);
				o_done_oe_n <= 1'b0;
			end else begin
				o_done_n <= 1'b1;
				o_done_oe_n <= 1'b1;
			end
		end
	end

	// the bus clock only counts activity during a load; no timeout is derived from it
	always @(posedge i_sys_clk) begin
		if (reg_rst) begin
			sdc_prev <= 1'b1;
			edge_cnt <= {`SSLC_EDGE_W{1'b0}};
		end else begin
			sdc_prev <= filt[`SSLC_SY_SDC];
			if (sdc_rise && (ld_state == `SSLC_LD_RUN)) begin
				edge_cnt <= edge_cnt + {{(`SSLC_EDGE_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// apb slave: one wait state, so pready and prdata both come from flops
	assign apb_req = i_psel && i_penable && !o_pready;
	assign idx = i_paddr[`SSLC_IDX_W+1:2];
	assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[31:`SSLC_IDX_W+2] == 0) &&
		((idx == `SSLC_IDX_STATUS) || (idx == `SSLC_IDX_MASK) ||
		(idx == `SSLC_IDX_INFO) || (idx == `SSLC_IDX_XPT) ||
		(idx == `SSLC_IDX_SHARED));
	assign rd_status = apb_req && !i_pwrite && (idx == `SSLC_IDX_STATUS) && addr_ok;

	always @* begin
		rd_mux = 32'h0;
		case (idx)
			`SSLC_IDX_STATUS: begin
				rd_mux[`SSLC_EV_W-1:0] = status;
			end
			`SSLC_IDX_MASK: begin
				rd_mux[`SSLC_EV_W-1:0] = mask;
			end
			`SSLC_IDX_INFO: begin
				rd_mux = {edge_cnt, 1'b0, o_target_addr, o_test_mode,
					slave_mode, ld_state, mode_lvl, captured, master_mode};
			end
			`SSLC_IDX_XPT: begin
				rd_mux[`SSLC_NPAIR-1:0] = o_xpoint_cross;
			end
			`SSLC_IDX_SHARED: begin
				rd_mux[`SSLC_SH_W-1:0] = shared;
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0;
		end else begin
			o_pready <= apb_req;
			o_pslverr <= apb_req && !addr_ok;
			o_prdata <= (apb_req && !i_pwrite && addr_ok) ? rd_mux : 32'h0;
		end
	end

	// a result outside a running load is ignored; ok wins if both pulse together
	assign ev_ok = (ld_state == `SSLC_LD_RUN) && i_eeprom_ok;
	assign ev_fail = (ld_state == `SSLC_LD_RUN) && !i_eeprom_ok && i_eeprom_fail;
	assign ev_hold = slave_hold && !hold_seen;
	assign ev_set = {ev_hold, ev_fail, ev_ok};

	// software registers; a slave-mode hold clears them like a reset
	always @(posedge i_sys_clk) begin
		if (reg_rst) begin
			mask <= `SSLC_EV_RST;
			shared <= `SSLC_SH_RST;
			xpt_reg <= {`SSLC_NPAIR{1'b0}};
		end else if (apb_req && i_pwrite && addr_ok) begin
			if (idx == `SSLC_IDX_MASK) begin
				mask <= i_pwdata[`SSLC_EV_W-1:0];
			end
			if (idx == `SSLC_IDX_SHARED) begin
				shared <= i_pwdata[`SSLC_SH_W-1:0];
			end
			if (idx == `SSLC_IDX_XPT) begin
				xpt_reg <= i_pwdata[`SSLC_NPAIR-1:0];
			end
		end
	end

	// hold event must survive the hold itself, so status clears on the system reset or a status read, not on the hold
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			status <= `SSLC_EV_RST;
			o_irq <= 1'b0;
		end else begin
			status <= (rd_status ? `SSLC_EV_RST : status) | ev_set;
			o_irq <= |(status & mask);
		end
	end

	// pairs 0 and 2 are channels 0-1 and 4-5, pairs 1 and 3 are 2-3 and 6-7
	assign pin_cross = {filt[`SSLC_SY_SELB], filt[`SSLC_SY_SELA],
		filt[`SSLC_SY_SELB], filt[`SSLC_SY_SELA]};

	generate
		for (g = 0; g < `SSLC_NPAIR; g = g + 1) begin : g_xpt
			always @(posedge i_sys_clk) begin
				if (reg_rst) begin
					o_xpoint_cross[g] <= 1'b0;
				end else if (shared[`SSLC_SH_PINCTL]) begin
					o_xpoint_cross[g] <= pin_cross[g];
				end else begin
					o_xpoint_cross[g] <= xpt_reg[g];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire
